// [dsap_pkg.sv]
package dsap_pkg;
   // Transfer size encodings
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_LINE = 2'h3;
   // Port width encodings
   localparam logic [1:0] PORT_8    = 2'h0;
   localparam logic [1:0] PORT_16   = 2'h1;
   localparam logic [1:0] PORT_32   = 2'h2;
   // Address pin counts
   localparam int DEDICATED_ADDR = 24;
   localparam int EXTRA_ADDR     = 4;
   localparam int PIN_ADDR       = DEDICATED_ADDR + EXTRA_ADDR;
   // Timing field widths and reset values
   localparam int TIMING_W = 3;
   localparam logic [2:0] TIMING_RST = 3'h0;
   localparam logic [3:0] STROBES_IDLE = 4'hf;
   localparam logic [1:0] RAS_IDLE = 2'h3;
endpackage

// [dsap_cas_decode.sv]
`timescale 1ns/100ps
// Byte lane strobe selection; output is active high (1 = assert lane)
module dsap_cas_decode
(
   // Transfer description
   input  wire logic [1:0] op_size,
   input  wire logic [1:0] port_width,
   input  wire logic [1:0] addr_low,
   // Lane enables, bit 0 is the top byte lane
   output logic      [3:0] lane_en
);
   // Lookup across port width, size and low address
   always_comb
   begin
      lane_en = 4'h0;
      case (port_width)
         dsap_pkg::PORT_8:
            lane_en = 4'h1;
         dsap_pkg::PORT_16:
            if (op_size == dsap_pkg::SIZE_BYTE)
               lane_en = addr_low[0] ? 4'h2 : 4'h1;
            else
               lane_en = 4'h3;
         dsap_pkg::PORT_32:
            case (op_size)
               dsap_pkg::SIZE_BYTE:
                  lane_en = 4'(4'h1 << addr_low);
               dsap_pkg::SIZE_WORD:
                  lane_en = addr_low[1] ? 4'hc : 4'h3;
               default:
                  lane_en = 4'hf;
            endcase
         default:
            lane_en = 4'h0;  // Unused code selects no lanes
      endcase
   end
endmodule

// [dsap_pins.sv]
`timescale 1ns/100ps
module dsap_pins
#(
   parameter int ADDR_W = 28
)
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   // Transfer request from the bus controller
   input  wire logic              xfer_start,
   input  wire logic              xfer_write,
   input  wire logic              xfer_ext_master,
   input  wire logic              xfer_bank,
   input  wire logic [1:0]        op_size,
   input  wire logic [1:0]        port_width,
   input  wire logic [ADDR_W-1:0] row_addr,
   input  wire logic [ADDR_W-1:0] col_addr,
   input  wire logic [ADDR_W-1:0] bus_addr,
   input  wire logic              refresh_start,
   // Configuration
   input  wire logic [2:0]        ras_to_cas_wait,
   input  wire logic [2:0]        cas_width_wait,
   input  wire logic              ext_master_addr_mux_enable,
   input  wire logic [3:0]        upper_addr_pin_enable,
   // Status
   output logic                   busy,
   output logic                   xfer_done,
   // DRAM pins
   output logic [1:0]             ras_n,
   output logic [3:0]             cas_n,
   output logic                   dram_write_strobe_n,
   output logic [1:0]             transfer_size,
   output logic [ADDR_W-1:0]      addr_out,
   output logic [ADDR_W-1:0]      addr_oe
);
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_ROW  = 3'b001,
      ST_COL  = 3'b010,
      ST_REF  = 3'b011,
      ST_REFR = 3'b100
   } dsap_state_t;

   dsap_state_t           state;
   logic [2:0]            wait_cnt;
   logic                  cur_write;
   logic                  cur_mux;
   logic                  cur_bank;
   logic [1:0]            cur_size;
   logic [1:0]            cur_port;
   logic [ADDR_W-1:0]     cur_row;
   logic [ADDR_W-1:0]     cur_col;
   logic [ADDR_W-1:0]     cur_flat;
   logic [3:0]            lane_en;
   logic [ADDR_W-1:0]     pin_is_addr;
   logic [ADDR_W-1:0]     next_addr;

   dsap_cas_decode u_dec
   (
      .op_size    (cur_size),
      .port_width (cur_port),
      .addr_low   (cur_flat[1:0]),
      .lane_en    (lane_en)
   );

   // Capture transfer attributes; the strobe decoder sees stable values
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cur_write <= 1'b0;
         cur_mux   <= 1'b0;
         cur_bank  <= 1'b0;
         cur_size  <= dsap_pkg::SIZE_LONG;
         cur_port  <= dsap_pkg::PORT_32;
         cur_row   <= '0;
         cur_col   <= '0;
         cur_flat  <= '0;
      end
      else if (state == ST_IDLE && !refresh_start && xfer_start)
      begin
         cur_write <= xfer_write;
         // Internal core always muxes; external only when enabled
         cur_mux   <= !xfer_ext_master
                      || ext_master_addr_mux_enable;
         cur_bank  <= xfer_bank;
         cur_size  <= op_size;
         cur_port  <= port_width;
         cur_row   <= row_addr;
         cur_col   <= col_addr;
         cur_flat  <= bus_addr;
      end
   end

   // Sequencer; refresh wins over a transfer arriving the same cycle
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state    <= ST_IDLE;
         wait_cnt <= dsap_pkg::TIMING_RST;
      end
      else
      begin
         case (state)
            ST_IDLE:
               if (refresh_start)
               begin
                  state    <= ST_REF;
                  wait_cnt <= ras_to_cas_wait;
               end
               else if (xfer_start)
               begin
                  state    <= ST_ROW;
                  wait_cnt <= ras_to_cas_wait;
               end
            ST_ROW, ST_REF:
               if (wait_cnt != 3'h0)
                  wait_cnt <= wait_cnt - 3'h1;
               else
               begin
                  state    <= (state == ST_ROW) ? ST_COL : ST_REFR;
                  wait_cnt <= cas_width_wait;
               end
            ST_COL, ST_REFR:
               if (wait_cnt != 3'h0)
                  wait_cnt <= wait_cnt - 3'h1;
               else
                  state <= ST_IDLE;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   assign busy      = (state != ST_IDLE);
   assign xfer_done = (state == ST_COL) && (wait_cnt == 3'h0);

   // Strobes registered so pins never glitch
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         ras_n               <= dsap_pkg::RAS_IDLE;
         cas_n               <= dsap_pkg::STROBES_IDLE;
         dram_write_strobe_n <= 1'b1;
         transfer_size       <= dsap_pkg::SIZE_LONG;
      end
      else
      begin
         case (state)
            ST_ROW:
            begin
               ras_n <= cur_bank ? 2'h1 : 2'h2;
               cas_n <= dsap_pkg::STROBES_IDLE;
               dram_write_strobe_n <= !cur_write;
               transfer_size <= cur_size;
            end
            ST_COL:
            begin
               ras_n <= cur_bank ? 2'h1 : 2'h2;
               cas_n <= ~lane_en;
               dram_write_strobe_n <= !cur_write;
               transfer_size <= cur_size;
            end
            ST_REF:
            begin
               // CAS before RAS refresh of both banks
               ras_n <= dsap_pkg::RAS_IDLE;
               cas_n <= 4'h0;
               dram_write_strobe_n <= 1'b1;
            end
            ST_REFR:
            begin
               ras_n <= 2'h0;
               cas_n <= 4'h0;
               dram_write_strobe_n <= 1'b1;
            end
            default:
            begin
               ras_n               <= dsap_pkg::RAS_IDLE;
               cas_n               <= dsap_pkg::STROBES_IDLE;
               dram_write_strobe_n <= 1'b1;
            end
         endcase
      end
   end

   // Dedicated pins always address; upper four only when selected
   always_comb
   begin
      pin_is_addr = '1;
      pin_is_addr[ADDR_W-1:dsap_pkg::DEDICATED_ADDR] =
         upper_addr_pin_enable;
   end

   // Row then column, or flat address when not multiplexing
   always_comb
   begin
      next_addr = cur_flat;
      if (cur_mux && state == ST_ROW)
         next_addr = cur_row;
      else if (cur_mux && state == ST_COL)
         next_addr = cur_col;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         addr_out <= '0;
         addr_oe  <= '0;
      end
      else
      begin
         addr_out <= next_addr & pin_is_addr;
         addr_oe  <= (state == ST_ROW || state == ST_COL) ?
                     pin_is_addr : '0;
      end
   end

   a_refresh_no_write: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      $past(state) inside {ST_REF, ST_REFR} |-> dram_write_strobe_n)
      else $error("write strobe asserted in refresh");
   a_one_bank_ras: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      $past(state) inside {ST_ROW, ST_COL} |-> ras_n[$past(cur_bank)] == 1'b0
      && ras_n[!$past(cur_bank)] == 1'b1)
      else $error("wrong bank row strobe");
   a_port8_cas: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      ($past(state) == ST_COL && $past(cur_port) == dsap_pkg::PORT_8)
      |-> cas_n == 4'he)
      else $error("8-bit port strobes wrong");
   a_port32_long: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      ($past(state) == ST_COL && $past(cur_port) == dsap_pkg::PORT_32 &&
      $past(cur_size) == dsap_pkg::SIZE_LONG) |-> cas_n == 4'h0)
      else $error("32-bit long strobes wrong");
   a_port16_word: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      ($past(state) == ST_COL && $past(cur_port) == dsap_pkg::PORT_16 &&
      $past(cur_size) != dsap_pkg::SIZE_BYTE) |-> cas_n == 4'hc)
      else $error("16-bit wide strobes wrong");
   a_write_follows: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      $past(state) == ST_COL |->
      dram_write_strobe_n == !$past(cur_write))
      else $error("write strobe mismatch");
   a_size_match: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      $past(state) == ST_COL |-> transfer_size == $past(cur_size))
      else $error("transfer size mismatch");
   a_pin_gate: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      ((addr_out | addr_oe) & ~$past(pin_is_addr)) == '0)
      else $error("address on non-address pin");
   a_cas_idle_row: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      $past(state) == ST_ROW |-> cas_n == 4'hf)
      else $error("column strobe before column phase");
endmodule

// [dsap_dram_model.sv]
`timescale 1ns/100ps
// Far-side DRAM: latches row and column on the strobe falls
module dsap_dram_model
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Pins from the controller
   input  wire logic [1:0]  ras_n,
   input  wire logic [3:0]  cas_n,
   input  wire logic        we_n,
   input  wire logic [27:0] addr,
   input  wire logic [27:0] addr_oe,
   // What the parts saw
   output logic      [27:0] row_q,
   output logic      [27:0] col_q,
   output logic      [3:0]  lane_q,
   output logic      [7:0]  n_ref
);
   logic [1:0]  ras_d;
   logic [3:0]  cas_d;
   logic [27:0] pin;
   // Undriven pins read inverted so a stale value cannot match
   assign pin = (addr & addr_oe) | (~addr & ~addr_oe);
   // Row on RAS fall, column and lanes on CAS fall
   always_ff @(posedge ref_clk)
   begin
      ras_d <= ras_n;
      cas_d <= cas_n;
      if (ras_d == 2'h3 && ras_n != 2'h3 && cas_n == 4'hf)
         row_q <= pin;
      if (cas_d == 4'hf && cas_n != 4'hf && ras_n != 2'h3)
      begin
         col_q <= pin;
         lane_q <= ~cas_n;
      end
   end
   // Count CAS-before-RAS refreshes only; a low write strobe would
   // spoil the refresh, so such a cycle is not counted
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         n_ref <= 8'h0;
      else if (ras_d == 2'h3 && ras_n == 2'h0 && cas_d == 4'h0 && we_n)
         n_ref <= n_ref + 8'h1;
   end
endmodule

// [dram_strobe_and_address_pins_test.sv]
`timescale 1ns/100ps
module dram_strobe_and_address_pins_test;
   logic        ref_clk, sys_rst, xfer_start, xfer_write, xfer_ext_master;
   logic        xfer_bank, refresh_start, mux_en, busy, xfer_done, we_n;
   logic [1:0]  op_size, port_width, ras_n, transfer_size;
   logic [2:0]  r_wait, c_wait;
   logic [3:0]  upper_en, cas_n, lane_q;
   logic [7:0]  n_ref;
   logic [27:0] row_addr, col_addr, bus_addr, addr_out, addr_oe;
   logic [27:0] row_q, col_q;
   int          n_fail, n_compared, seed, n_done;
   dsap_pins i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .xfer_start(xfer_start), .xfer_write(xfer_write),
      .xfer_ext_master(xfer_ext_master), .xfer_bank(xfer_bank),
      .op_size(op_size), .port_width(port_width), .row_addr(row_addr),
      .col_addr(col_addr), .bus_addr(bus_addr),
      .refresh_start(refresh_start), .ras_to_cas_wait(r_wait),
      .cas_width_wait(c_wait), .ext_master_addr_mux_enable(mux_en),
      .upper_addr_pin_enable(upper_en), .busy(busy), .xfer_done(xfer_done),
      .ras_n(ras_n), .cas_n(cas_n), .dram_write_strobe_n(we_n),
      .transfer_size(transfer_size), .addr_out(addr_out),
      .addr_oe(addr_oe));
   dsap_dram_model i_dram (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr_out),
      .addr_oe(addr_oe), .row_q(row_q), .col_q(col_q), .lane_q(lane_q),
      .n_ref(n_ref));
   // 125 MHz
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Done pulses, counted mid-cycle where the flag is settled
   always @(negedge ref_clk)
      if (xfer_done === 1'b1)
         n_done++;
   task automatic tick;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic conclude;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [27:0] g, input logic [27:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // A bounded wait that ran out ends the run
   task automatic limit(input int k);
      if (k >= 20)
      begin
         n_fail++;
         conclude();
      end
   endtask
   // Expected byte lanes, bit 0 the top lane
   function automatic logic [3:0] lanes(input logic [1:0] sz, pw, a);
      if (pw == dsap_pkg::PORT_8)
         return 4'h1;
      if (sz == dsap_pkg::SIZE_BYTE)
         return (pw == dsap_pkg::PORT_16) ? 4'h1 << a[0] : 4'h1 << a;
      if (pw == dsap_pkg::PORT_16)
         return 4'h3;
      if (sz == dsap_pkg::SIZE_WORD)
         return a[1] ? 4'hc : 4'h3;
      return 4'hf;
   endfunction
   task automatic run(input logic em, input logic [1:0] sz, pw, a,
                      input logic [2:0] r, c);
      logic [27:0] m, er, ec;
      int          k, d0;
      xfer_write = 1'($random(seed));
      xfer_bank = 1'($random(seed));
      xfer_ext_master = em;
      op_size = sz;
      port_width = pw;
      r_wait = r;
      c_wait = c;
      upper_en = 4'($random(seed));
      row_addr = {26'($random(seed)), a};
      col_addr = {26'($random(seed)), a};
      bus_addr = {26'($random(seed)), a};
      m = {upper_en, 24'hffffff};
      er = (em && !mux_en) ? bus_addr : row_addr;
      ec = (em && !mux_en) ? bus_addr : col_addr;
      d0 = n_done;
      xfer_start = 1'b1;
      tick;
      xfer_start = 1'b0;
      for (k = 0; ras_n === 2'h3 && k < 20; k++)
         tick;
      limit(k);
      chk(28'(k), 28'h1);
      chk(ras_n, 2'(~(2'h1 << xfer_bank)));
      chk(addr_oe, m);
      for (k = 0; cas_n === 4'hf && k < 20; k++)
         tick;
      limit(k);
      chk(28'(k), r + 1);
      chk(cas_n, 4'(~lanes(sz, pw, a)));
      chk(transfer_size, sz);
      chk(we_n, !xfer_write);
      for (k = 0; busy !== 1'b0 && k < 20; k++)
         tick;
      limit(k);
      tick;
      chk({ras_n, cas_n}, 6'h3f);
      chk(row_q & m, er & m);
      chk(col_q & m, ec & m);
      chk(lane_q, lanes(sz, pw, a));
      chk(28'(n_done - d0), 28'h1);
   endtask
   initial
   begin
      logic [1:0] a;
      logic [7:0] nr;
      int         i, k, nd;
      seed = 86677;
      n_fail = 0;
      n_compared = 0;
      {xfer_start, xfer_write, xfer_ext_master, xfer_bank} = 4'h0;
      {refresh_start, mux_en, op_size, port_width} = 6'h0;
      {r_wait, c_wait, upper_en} = 10'h0;
      {row_addr, col_addr, bus_addr} = '0;
      sys_rst = 1'b1;
      repeat (2) tick;
      sys_rst = 1'b0;
      chk({ras_n, cas_n, we_n}, 7'h7f);
      // Every size and port, random low address (even unless byte, zero for long and line on the 32-bit port), back to back
      for (i = 0; i < 48; i++)
      begin
         a = 2'($random(seed));
         if (i % 4 != 1)
            a[0] = 1'b0;
         if (i % 4 != 1 && i % 4 != 2 && (i / 4) % 3 == 2)
            a = 2'h0;
         run(1'b0, 2'(i % 4), 2'((i / 4) % 3), a, 3'($random(seed)),
             3'($random(seed)));
      end
      $display("test lanes done");
      run(1'b0, dsap_pkg::SIZE_LONG, dsap_pkg::PORT_32, 2'h0, 3'h0, 3'h0);
      run(1'b0, dsap_pkg::SIZE_LINE, dsap_pkg::PORT_32, 2'h0, 3'h7, 3'h7);
      $display("test timing done");
      for (i = 0; i < 4; i++)
      begin
         mux_en = i[0];
         run(1'b1, dsap_pkg::SIZE_BYTE, dsap_pkg::PORT_32, 2'(i), 3'h1,
             3'h2);
      end
      $display("test ext master done");
      // Refresh with the bus showing a write
      nr = n_ref;
      // A transfer asked for in the same cycle must lose to refresh
      nd = n_done;
      xfer_write = 1'b1;
      xfer_start = 1'b1;
      refresh_start = 1'b1;
      tick;
      xfer_start = 1'b0;
      refresh_start = 1'b0;
      for (k = 0; busy !== 1'b0 && k < 20; k++)
      begin
         chk(we_n, 1'b1);
         tick;
      end
      limit(k);
      tick;
      chk(n_ref, nr + 8'h1);
      chk(28'(n_done - nd), 28'h0);
      $display("test refresh done");
      conclude();
   end
endmodule
